// File: ddil_buf.sv
// two-entry word buffer with valid and ready on both sides
module ddil_buf
  import ddil_pkg::*;
#(
  parameter int unsigned W = DATA_W
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_valid,
  output logic              o_ready,
  output logic      [W-1:0] o_data,
  output logic              o_valid,
  input  wire logic         i_ready
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              wr;
    logic              rd;
    logic [1:0]        cnt;
  } ddil_buf_st_t;

  ddil_buf_st_t s;
  ddil_buf_st_t next_s;
  logic         push;
  logic         pop;

  assign o_ready = (s.cnt != 2'h2);
  assign o_valid = (s.cnt != 2'h0);
  assign o_data  = s.mem[s.rd];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  // pointers wrap at two entries; count gives honest full and empty
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr] = i_data;
      next_s.wr        = ~s.wr;
    end
    if (pop) begin
      next_s.rd = ~s.rd;
    end
    case ({push, pop})
      2'b10:   next_s.cnt = s.cnt + 2'h1;
      2'b01:   next_s.cnt = s.cnt - 2'h1;
      default: next_s.cnt = s.cnt;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// File: ddil_host.sv
// host model: sample words, write strobes and update clocks
module ddil_host
  import ddil_pkg::*;
(
  input  wire logic              i_ref_clk,
  output logic      [DATA_W-1:0] o_data_a,
  output logic      [DATA_W-1:0] o_data_b,
  output logic      [1:0]        o_wrt,
  output logic      [1:0]        o_upd
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle low from time zero, words msb at the top index
  initial begin
    o_data_a = '0;
    o_data_b = '0;
    o_wrt    = '0;
    o_upd    = '0;
  end
  // pins move at the falling edge, away from the capture edge
  // update rise comes with the strobe or alone, never after it
  // strobe and clock stay separate pins, safe at either supply
  task automatic xfer(input int ch, input logic [DATA_W-1:0] d, input logic wr,
                      input logic up, input int idle);
    @(negedge i_ref_clk);
    o_data_a  = (ch == 0) ? d : o_data_a;
    o_data_b  = (ch == 1) ? d : o_data_b;
    o_wrt[ch] = wr;
    o_upd[ch] = up;
    @(negedge i_ref_clk);
    // stale word shown inverted so a late capture cannot pass
    o_data_a  = (ch == 0) ? ~d : o_data_a;
    o_data_b  = (ch == 1) ? ~d : o_data_b;
    o_wrt[ch] = 1'b0;
    o_upd[ch] = 1'b0;
    repeat (idle) @(negedge i_ref_clk);
  endtask
  // select moves only while shared strobe and clock are low
  task automatic set_sel(input logic s);
    @(negedge i_ref_clk);
    o_wrt[1] = s;
  endtask
  // sync pulse holding a shared clock rise that must be ignored
  task automatic sync();
    @(negedge i_ref_clk);
    o_upd[1] = 1'b1;
    xfer(0, '0, 1'b0, 1'b1, 0);
    o_upd[1] = 1'b0;
  endtask
endmodule

// File: ddil_pkg.sv
// constants shared by the dual converter input latch front end
package ddil_pkg;
  localparam int unsigned DATA_W        = 14;
  localparam int unsigned BUF_DEPTH     = 2;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PWRDN_NS      = 50;
  localparam int unsigned PWRUP_NS      = 5000;
  // longest time rounds down, at least one cycle
  localparam int unsigned PWRDN_CYC =
    (PWRDN_NS / CLK_PERIOD_NS) < 1 ? 1 : (PWRDN_NS / CLK_PERIOD_NS);
  // least time rounds up
  localparam int unsigned PWRUP_CYC = (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PWR_CNT_W = 8;
  localparam logic [DATA_W-1:0]    DATA_RST    = 14'h0000;
  localparam logic [PWR_CNT_W-1:0] PWR_CNT_RST = 8'h00;
  localparam logic                 MODE_DUAL   = 1'b1;
endpackage

// File: ddil_rise.sv
// rising edge detector for one synchronous control input
module ddil_rise
  import ddil_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  input  wire logic i_level,
  output logic      o_rise
);
  typedef struct packed {
    logic prev;
  } ddil_rise_st_t;

  ddil_rise_st_t s;
  ddil_rise_st_t next_s;

  // previous level held so a high level gives one pulse only
  always_comb begin
    next_s      = s;
    next_s.prev = i_level;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_rise = i_level & ~s.prev;
endmodule

// File: ddil_top.sv
// dual converter input latch front end: dual-port and interleaved modes
module ddil_top
  import ddil_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_mode,
  input  wire logic [DATA_W-1:0] i_data_a,
  input  wire logic [DATA_W-1:0] i_data_b,
  input  wire logic              i_chan_a_write_strobe,
  input  wire logic              i_chan_b_write_strobe,
  input  wire logic              i_chan_a_update_clock,
  input  wire logic              i_chan_b_update_clock,
  input  wire logic              i_sleep,
  input  wire logic              i_latch_ready,
  output logic                   o_write_ready_a,
  output logic                   o_write_ready_b,
  output logic      [DATA_W-1:0] o_input_latch_a,
  output logic      [DATA_W-1:0] o_input_latch_b,
  output logic      [DATA_W-1:0] o_dac_code_a,
  output logic      [DATA_W-1:0] o_dac_code_b,
  output logic      [DATA_W-1:0] o_dac_comp_a,
  output logic      [DATA_W-1:0] o_dac_comp_b,
  output logic                   o_current_on,
  output logic                   o_output_valid,
  output logic                   o_phase_locked
);
  typedef struct packed {
    logic [DATA_W-1:0]    in_a;
    logic [DATA_W-1:0]    in_b;
    logic [DATA_W-1:0]    conv_a;
    logic [DATA_W-1:0]    conv_b;
    logic                 sync_held;
    logic                 phase_known;
    logic                 phase;
    logic                 last_ld;
    logic                 down;
    logic [PWR_CNT_W-1:0] wake_cnt;
  } ddil_st_t;

  ddil_st_t          s;
  ddil_st_t          next_s;
  logic              rise_wa;
  logic              rise_wb;
  logic              rise_ca;
  logic              rise_cb;
  logic              dual;
  logic              sel;
  logic              sync_rst;
  logic              push_a;
  logic              push_b;
  logic [DATA_W-1:0] word_b;
  logic              valid_a;
  logic              valid_b;
  logic [DATA_W-1:0] buf_a;
  logic [DATA_W-1:0] buf_b;
  logic              ld_a;
  logic              ld_b;
  logic              ld_both;

  // one edge detector per control pin
  ddil_rise u_rise_wa (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_level   (i_chan_a_write_strobe),
    .o_rise    (rise_wa)
  );
  ddil_rise u_rise_wb (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_level   (i_chan_b_write_strobe),
    .o_rise    (rise_wb)
  );
  ddil_rise u_rise_ca (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_level   (i_chan_a_update_clock),
    .o_rise    (rise_ca)
  );
  ddil_rise u_rise_cb (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_level   (i_chan_b_update_clock),
    .o_rise    (rise_cb)
  );

  // pin roles depend on mode
  assign dual     = (i_mode == MODE_DUAL);
  assign sel      = i_chan_b_write_strobe;
  assign sync_rst = i_chan_b_update_clock;

  // steering of written words into the two channels
  assign push_a = dual ? rise_wa : (rise_wa & sel);
  assign push_b = dual ? rise_wb : (rise_wa & ~sel);
  assign word_b = dual ? i_data_b : i_data_a;

  // buffers hold up to two words while the latch side stalls; a word written to a full buffer is lost
  ddil_buf #(.W(DATA_W)) u_buf_a (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_data    (i_data_a),
    .i_valid   (push_a),
    .o_ready   (o_write_ready_a),
    .o_data    (buf_a),
    .o_valid   (valid_a),
    .i_ready   (i_latch_ready)
  );
  ddil_buf #(.W(DATA_W)) u_buf_b (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_data    (word_b),
    .i_valid   (push_b),
    .o_ready   (o_write_ready_b),
    .o_data    (buf_b),
    .o_valid   (valid_b),
    .i_ready   (i_latch_ready)
  );

  // converter latch load strobes
  always_comb begin
    ld_both = 1'b0;
    if (!dual && !sync_rst && rise_ca) begin
      ld_both = s.sync_held | ~s.phase;
    end
    ld_a = dual ? rise_ca : ld_both;
    ld_b = dual ? rise_cb : ld_both;
  end

  // whole next state; converter takes the input latch as it stands,
  // so a clock before or with the strobe moves the older word
  always_comb begin
    next_s = s;
    if (valid_a && i_latch_ready) begin
      next_s.in_a = buf_a;
    end
    if (valid_b && i_latch_ready) begin
      next_s.in_b = buf_b;
    end
    if (ld_a) begin
      next_s.conv_a = s.in_a;
    end
    if (ld_b) begin
      next_s.conv_b = s.in_b;
    end
    // divider: phase is free-running until first sync reset
    if (!dual) begin
      if (sync_rst) begin
        next_s.sync_held = 1'b1;
      end else if (rise_ca) begin
        // shadow of this edge's load, kept apart from the phase bit
        next_s.last_ld = ld_both;
        if (s.sync_held) begin
          next_s.sync_held   = 1'b0;
          next_s.phase_known = 1'b1;
          next_s.phase       = 1'b1;
        end else begin
          next_s.phase = ~s.phase;
        end
      end
    end
    // sleep: down next edge, wake counter then output valid
    next_s.down = i_sleep;
    if (i_sleep) begin
      next_s.wake_cnt = PWR_CNT_W'(PWRUP_CYC);
    end else if (s.wake_cnt != PWR_CNT_RST) begin
      next_s.wake_cnt = s.wake_cnt - 8'h01;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '{in_a: DATA_RST, in_b: DATA_RST, conv_a: DATA_RST, conv_b: DATA_RST,
             sync_held: 1'b0, phase_known: 1'b0, phase: 1'b0, last_ld: 1'b0, down: 1'b0,
             wake_cnt: PWR_CNT_RST};
    end else begin
      s <= next_s;
    end
  end

  // straight binary code and its complement for the two outputs
  assign o_input_latch_a = s.in_a;
  assign o_input_latch_b = s.in_b;
  assign o_dac_code_a    = s.conv_a;
  assign o_dac_code_b    = s.conv_b;
  assign o_dac_comp_a    = ~s.conv_a;
  assign o_dac_comp_b    = ~s.conv_b;
  assign o_current_on    = ~s.down;
  assign o_output_valid  = ~s.down & (s.wake_cnt == PWR_CNT_RST);
  assign o_phase_locked  = s.phase_known;

  // checks on the design's own behaviour
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // dual-port strobes push their own channel only, both may rise together
  dual_strobe_a: assert property (dual |-> push_a == rise_wa && push_b == rise_wb)
    else $error("dual strobe did not push its own channel only");

  // divider left untouched while in dual-port mode
  dual_div_a: assert property (dual |=> $stable(s.phase) && $stable(s.sync_held))
    else $error("interleave divider moved in dual-port mode");

  // channel b converter ignores channel a activity
  dual_iso_a: assert property (dual && !rise_cb |=> $stable(o_dac_code_b))
    else $error("channel b converter moved without its clock");

  // channel a converter ignores channel b activity
  dual_keep_a: assert property (dual && !rise_ca |=> $stable(o_dac_code_a))
    else $error("channel a converter moved without its clock");

  // first stage a takes the drained word
  fill_first_a: assert property (valid_a && i_latch_ready
                                 |=> o_input_latch_a == $past(buf_a))
    else $error("input latch a did not take the buffered word");

  // first stage b takes the drained word
  fill_second_a: assert property (valid_b && i_latch_ready
                                  |=> o_input_latch_b == $past(buf_b))
    else $error("input latch b did not take the buffered word");

  // converter a moves only on a load
  conv_src_a: assert property ($changed(o_dac_code_a) |-> $past(ld_a))
    else $error("converter latch a changed without a load");

  // converter b moves only on a load
  second_src_a: assert property ($changed(o_dac_code_b) |-> $past(ld_b))
    else $error("converter latch b changed without a load");

  // update clock a copies input latch a
  dual_load_a: assert property (dual && rise_ca |=> o_dac_code_a == $past(s.in_a))
    else $error("update clock did not load converter a");

  // update clock b copies input latch b
  second_load_a: assert property (dual && rise_cb |=> o_dac_code_b == $past(s.in_b))
    else $error("update clock did not load converter b");

  // channel b strobe pin writes nothing when interleaved
  il_idle_a: assert property (!dual && !rise_wa |-> !push_a && !push_b)
    else $error("interleaved write without a shared strobe edge");

  // shared data port feeds both channels
  il_word_a: assert property (!dual |-> word_b == i_data_a)
    else $error("interleaved channel b not fed from the shared port");

  // select low steers to channel b
  il_steer_a: assert property (!dual && rise_wa && !sel |-> push_b && !push_a)
    else $error("select low did not steer to channel b");

  // select high steers to channel a
  il_route_a: assert property (!dual && rise_wa && sel |-> push_a && !push_b)
    else $error("select high did not steer to channel a");

  // sync reset blocks every converter load
  sync_hold_a: assert property (!dual && sync_rst
                                |=> $stable(o_dac_code_a) && $stable(o_dac_code_b))
    else $error("converter loaded while sync reset high");

  // sync reset arms the first-edge load
  sync_mark_a: assert property (!dual && sync_rst |=> s.sync_held)
    else $error("sync reset did not arm the first-edge load");

  // first edge after sync reset loads both
  first_edge_a: assert property (!dual && !sync_rst && s.sync_held && rise_ca
                                 |=> o_dac_code_a == $past(s.in_a)
                                     && o_dac_code_b == $past(s.in_b))
    else $error("first edge after sync reset did not load both");

  // a loading shared edge is followed by a skipped one
  div_skip_a: assert property (!dual && !sync_rst && rise_ca && !s.sync_held && s.last_ld
                               |-> !ld_both)
    else $error("converter loaded on consecutive shared clock edges");

  // a skipped shared edge is followed by a loading one
  div_load_a: assert property (!dual && !sync_rst && rise_ca && !s.sync_held && !s.last_ld
                               |-> ld_both)
    else $error("converter skipped two shared clock edges in a row");

  // converters rest between shared clock edges
  il_quiet_a: assert property (!dual && !rise_ca
                               |=> $stable(o_dac_code_a) && $stable(o_dac_code_b))
    else $error("converter loaded without a shared clock edge");

  // sleep stops current and valid on the next edge
  sleep_down_a: assert property (i_sleep |=> !o_current_on && !o_output_valid)
    else $error("sleep did not stop output current within one cycle");

  // released sleep brings current back next edge
  wake_on_a: assert property (!i_sleep |=> o_current_on)
    else $error("output current off without sleep");

  // no early valid after release
  wake_wait_a: assert property ($fell(i_sleep) ##1 !i_sleep [*8] |-> !o_output_valid)
    else $error("output valid too soon after sleep release");

  // counter end raises output valid
  wake_end_a: assert property (!i_sleep && s.wake_cnt == 8'h01 |=> o_output_valid)
    else $error("output valid not raised at end of wake-up");

  // output valid rises only from the counter end
  wake_rise_a: assert property ($rose(o_output_valid) |-> $past(s.wake_cnt) == 8'h01)
    else $error("output valid rose before wake-up finished");

  // armed first edge fixes the divider phase
  lock_set_a: assert property (!dual && !sync_rst && s.sync_held && rise_ca |=> o_phase_locked)
    else $error("divider phase not fixed by first edge after sync reset");

  // lock comes only from an armed first edge
  lock_cause_a: assert property ($rose(o_phase_locked) |-> $past(s.sync_held))
    else $error("divider phase fixed without a sync reset");
endmodule

// File: ddil_top_test.sv
// self-checking bench for the dual converter input latch front end
module ddil_top_test
  import ddil_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   i_ref_clk     = 1'b0;
  logic                   i_rst_n       = 1'b0;
  logic                   i_mode        = 1'b1;
  logic                   i_sleep       = 1'b0;
  logic                   i_latch_ready = 1'b1;
  logic      [DATA_W-1:0] data_a, data_b;
  logic      [1:0]        write_strobe, upd;
  wire logic [DATA_W-1:0] lat [2], dac [2], comp [2];
  wire logic              rdy_a, rdy_b, cur_on, out_ok, ph_lock;
  logic      [DATA_W-1:0] ql [2][$], qd [2][$];
  logic      [DATA_W-1:0] exp_lat [2] = '{default: '0}, exp_dac [2] = '{default: '0};
  logic      [DATA_W-1:0] plat [2] = '{default: '0}, pdac [2] = '{default: '0};
  logic      [15:0]       seed = 16'h0035;
  int                     err_count = 0, checked = 0, cyc = 0;

  ddil_top uut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_mode(i_mode),
    .i_data_a(data_a), .i_data_b(data_b), .i_chan_a_write_strobe(write_strobe[0]),
    .i_chan_b_write_strobe(write_strobe[1]), .i_chan_a_update_clock(upd[0]),
    .i_chan_b_update_clock(upd[1]), .i_sleep(i_sleep), .i_latch_ready(i_latch_ready),
    .o_write_ready_a(rdy_a), .o_write_ready_b(rdy_b), .o_input_latch_a(lat[0]),
    .o_input_latch_b(lat[1]), .o_dac_code_a(dac[0]), .o_dac_code_b(dac[1]),
    .o_dac_comp_a(comp[0]), .o_dac_comp_b(comp[1]), .o_current_on(cur_on),
    .o_output_valid(out_ok), .o_phase_locked(ph_lock));
  ddil_host host (.i_ref_clk(i_ref_clk), .o_data_a(data_a), .o_data_b(data_b),
    .o_wrt(write_strobe), .o_upd(upd));

  // free-running 20 MHz reference
  initial begin
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  function automatic logic [DATA_W-1:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[DATA_W-1:0];
  endfunction

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // an unchanged word shows no edge, so only real changes are noted
  task automatic note_dac(input int ch);
    if (exp_lat[ch] !== exp_dac[ch]) begin
      qd[ch].push_back(exp_lat[ch]);
      exp_dac[ch] = exp_lat[ch];
    end
  endtask

  // write one word; a same-edge update takes the older latch word
  task automatic put(input int ch, input int pin, input logic up, input int idle);
    logic [DATA_W-1:0] d;
    d = rnd();
    if (up) note_dac(ch);
    ql[ch].push_back(d);
    exp_lat[ch] = d;
    host.xfer(pin, d, 1'b1, up, idle);
  endtask

  // update rise alone; interleaved loads fill both channels
  task automatic tick(input int ch, input logic load);
    if (load) note_dac(ch);
    if (load && i_mode == 1'b0) note_dac(1);
    host.xfer(ch, rnd(), 1'b0, 1'b1, 1);
  endtask

  // each latch or code change takes the oldest note of its channel
  always @(negedge i_ref_clk) begin
    if (i_rst_n) begin
      for (int i = 0; i < 2; i++) begin
        if (lat[i] !== plat[i]) begin
          check(lat[i], (ql[i].size() > 0) ? ql[i].pop_front() : plat[i]);
          plat[i] = lat[i];
        end
        if (dac[i] !== pdac[i]) begin
          check(dac[i], (qd[i].size() > 0) ? qd[i].pop_front() : pdac[i]);
          pdac[i] = dac[i];
        end
        check(comp[i], ~dac[i]);
      end
    end
  end

  // hang guard: the sequence needs well under a thousand cycles
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    int                n;
    logic [DATA_W-1:0] r;
    repeat (16) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    check(lat[0] | lat[1] | dac[0] | dac[1], '0);
    check(DATA_W'({cur_on, out_ok, ph_lock, rdy_a, rdy_b}), 14'h001B);
    put(0, 0, 1'b0, 0);
    put(1, 1, 1'b0, 2);
    tick(0, 1'b1);
    tick(1, 1'b1);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      put(int'(r[0]), int'(r[0]), r[1], int'(r[3:2]));
    end
    $display("test dual port done");
    @(negedge i_ref_clk); // last loop word may still sit in the buffer
    // stalled drain: two words fill the buffer, a third is dropped
    i_latch_ready = 1'b0;
    put(0, 0, 1'b0, 0);
    put(0, 0, 1'b0, 0);
    check(DATA_W'({rdy_a, rdy_b}), 14'h0001);
    host.xfer(0, rnd(), 1'b1, 1'b0, 0);
    i_latch_ready = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    tick(0, 1'b1);
    $display("test buffer done");
    i_sleep = 1'b1;
    @(negedge i_ref_clk);
    check(DATA_W'({cur_on, out_ok}), '0);
    i_sleep = 1'b0;
    n = 0;
    while (out_ok !== 1'b1 && n < 300) begin
      @(negedge i_ref_clk);
      n++;
    end
    check(DATA_W'(n >= PWRUP_CYC - 1 && n <= PWRUP_CYC + 1), 14'h0001);
    $display("test sleep done");
    i_mode = 1'b0;
    // fresh word in latch b: the held shared clock rise must not move it
    put(1, 0, 1'b0, 1);
    check(DATA_W'(ph_lock), '0);
    host.sync();
    host.set_sel(1'b1);
    put(0, 0, 1'b0, 1);
    host.set_sel(1'b0);
    put(1, 0, 1'b0, 1);
    tick(0, 1'b1);
    check(DATA_W'(ph_lock), 14'h0001);
    host.set_sel(1'b1);
    put(0, 0, 1'b0, 1);
    host.set_sel(1'b0);
    put(1, 0, 1'b0, 1);
    tick(0, 1'b0);
    tick(0, 1'b1);
    repeat (4) @(negedge i_ref_clk);
    check(DATA_W'(ql[0].size() + ql[1].size() + qd[0].size() + qd[1].size()), '0);
    $display("test interleaved done");
    close_out();
  end
endmodule
